// File: rtl/synth_program_registers.sv
`timescale 1ns/1ns
// Functional notes
// - Word with low bits 00 loads the feedback divider register.
// - Feedback word holds 9-bit whole divide and 12-bit numerator.
// - Fast-lock bit boosts pump to 16x until timer expires, then 1x.
// - Word with low bits 01 loads the reference divider register.
// - Bit 23 steers bits 13:2 to denominator or fast-lock timer.
// - Fast-lock timer counts comparator cycles.
// - Bits 22:20 of reference word select the test output signal.
// - Lock after run of errors under 15 ns; lost above 30 ns or new channel.
// - Precision bit selects 24 or 40 cycle lock run.
// - Four-bit reference divider divides by 1 to 15.
// - New denominator applies only after next feedback word write.
// - Control bit 2 holds the reference counter in reset and raises counterHold.
// - Control bit 3 three-states the charge pump.
// - Control bit 4 powers down; register contents are kept.
// - Power-down holds counters in reset, three-states pump, resets lock; loading still works.
// - Control bit 6 sets phase detector polarity.
// - Control bits 10:7 set the charge pump current.
// - Control bit 11 picks falling edges only or both reference edges.
// - Word with low bits 11 loads the noise and spur register.
// - Lowest-spur mode dithers; other modes do not; lowest-noise biases pump.
module synth_program_registers #(
  parameter logic [5:0] LOCK_RUN_LOW = sp_pkg::LOCK_RUN_LOW,
  parameter logic [5:0] LOCK_RUN_HIGH = sp_pkg::LOCK_RUN_HIGH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Serial programming port
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadStrobe,
  // Analog sense
  input wire logic referenceInput,
  input wire logic phaseErrorPulse,
  // Test output pin
  output logic testOut,
  output logic testOutEn,
  // Loop control
  output logic lockDetect,
  output logic [4:0] pumpGain,
  output logic pumpHighZ,
  output logic phasePolarity,
  output logic [3:0] pumpCurrentSet,
  output logic pumpNoiseBias,
  output logic ditherEn,
  // Divider settings
  output logic counterHold,
  output logic powerDown,
  output logic prescalerHigh,
  output logic refDoublerEn,
  output logic [8:0] wholeDivide,
  output logic [11:0] partialStepNumerator,
  output logic [11:0] fractionDenominator,
  output logic phaseComparatorTick
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Link domain: the host stops the clock while the strobe is high,
  // so the word is static when the mclk side takes it.
  logic [23:0] shiftWord_ff;
  always_ff @(posedge serialClk) begin
    shiftWord_ff <= {shiftWord_ff[22:0], serialData};
  end

  logic loadSync1_ff, loadSync2_ff, loadPrev_ff;
  logic refSync1_ff, refSync2_ff, refPrev_ff;
  logic errSync1_ff, errSync2_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      {loadSync1_ff, loadSync2_ff, loadPrev_ff} <= 3'h0;
      {refSync1_ff, refSync2_ff, refPrev_ff} <= 3'h0;
      {errSync1_ff, errSync2_ff} <= 2'h0;
    end else begin
      {loadSync1_ff, loadSync2_ff, loadPrev_ff} <= {loadStrobe, loadSync1_ff, loadSync2_ff};
      {refSync1_ff, refSync2_ff, refPrev_ff} <= {referenceInput, refSync1_ff, refSync2_ff};
      {errSync1_ff, errSync2_ff} <= {phaseErrorPulse, errSync1_ff};
    end
  end

  // Word decode
  wire loadRise = loadSync2_ff & ~loadPrev_ff;
  wire [1:0] wordAddr = shiftWord_ff[1:0];
  wire feedbackWrite = loadRise && (wordAddr == sp_pkg::ADDR_FEEDBACK);
  wire referenceWrite = loadRise && (wordAddr == sp_pkg::ADDR_REFERENCE);
  wire controlWrite = loadRise && (wordAddr == sp_pkg::ADDR_CONTROL);
  wire noiseWrite = loadRise && (wordAddr == sp_pkg::ADDR_NOISE);
  sp_pkg::feedback_word_t inFeedback;
  sp_pkg::reference_word_t inReference;
  assign inFeedback = sp_pkg::feedback_word_t'(shiftWord_ff);
  assign inReference = sp_pkg::reference_word_t'(shiftWord_ff);

  sp_pkg::feedback_word_t feedbackWord_ff;
  sp_pkg::reference_word_t referenceWord_ff;
  sp_pkg::control_word_t controlWord_ff;
  sp_pkg::noise_word_t noiseWord_ff;
  logic [11:0] denomPending_ff, denomActive_ff, timerValue_ff;

  // Power-down never touches these; the serial path keeps loading
  always_ff @(posedge mclk) begin
    if (reset) begin
      feedbackWord_ff <= sp_pkg::WORD_RESET;
      referenceWord_ff <= sp_pkg::WORD_RESET;
      controlWord_ff <= sp_pkg::WORD_RESET;
      noiseWord_ff <= sp_pkg::WORD_RESET;
    end else begin
      if (feedbackWrite) feedbackWord_ff <= inFeedback;
      if (referenceWrite) referenceWord_ff <= inReference;
      if (controlWrite) controlWord_ff <= sp_pkg::control_word_t'(shiftWord_ff);
      if (noiseWrite) noiseWord_ff <= sp_pkg::noise_word_t'(shiftWord_ff);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      denomPending_ff <= sp_pkg::VALUE_RESET;
      denomActive_ff <= sp_pkg::VALUE_RESET;
      timerValue_ff <= sp_pkg::VALUE_RESET;
    end else begin
      if (referenceWrite && !inReference.loadTimer) denomPending_ff <= inReference.value;
      if (referenceWrite && inReference.loadTimer) timerValue_ff <= inReference.value;
      if (feedbackWrite) denomActive_ff <= denomPending_ff;
    end
  end

  // Reference path
  wire countersHeld = controlWord_ff.counterReset | controlWord_ff.powerDown;
  wire refFall = refPrev_ff & ~refSync2_ff;
  wire refAny = refPrev_ff ^ refSync2_ff;
  wire refEdge = controlWord_ff.refDoubler ? refAny : refFall;
  // Ratio 0 is not valid; it is run as divide by one
  wire [3:0] rawRatio = referenceWord_ff.refRatio;
  wire [3:0] refRatio = (rawRatio == 4'h0) ? sp_pkg::REF_RATIO_MIN : rawRatio;
  logic [3:0] refCount_ff;
  logic pfdTick_ff;
  wire refWrap = refEdge && (refCount_ff == (refRatio - sp_pkg::REF_RATIO_MIN));
  always_ff @(posedge mclk) begin
    if (reset || countersHeld) begin
      refCount_ff <= 4'h0;
      pfdTick_ff <= 1'b0;
    end else begin
      pfdTick_ff <= refWrap;
      if (refWrap) refCount_ff <= 4'h0;
      else if (refEdge) refCount_ff <= refCount_ff + 4'h1;
    end
  end

  // Phase error width in mclk cycles, one window per comparator cycle
  logic [3:0] errWidth_ff;
  always_ff @(posedge mclk) begin
    if (reset) errWidth_ff <= 4'h0;
    else if (pfdTick_ff) errWidth_ff <= {3'h0, errSync2_ff};
    else if (errSync2_ff && errWidth_ff != sp_pkg::ERR_SAT) errWidth_ff <= errWidth_ff + 4'h1;
  end

  // Lock detect
  wire errSmall = errWidth_ff < sp_pkg::LOCK_ERR_CYC;
  wire errLarge = errWidth_ff > sp_pkg::UNLOCK_ERR_CYC;
  wire [5:0] runTarget = controlWord_ff.lockCountPrecision ? LOCK_RUN_HIGH : LOCK_RUN_LOW;
  logic [5:0] lockRun_ff;
  logic lockDetect_ff;
  wire [5:0] runNext = lockRun_ff + 6'h01;
  wire runHit = pfdTick_ff && errSmall && (runNext >= runTarget);
  wire lockClear = feedbackWrite | controlWord_ff.powerDown;
  always_ff @(posedge mclk) begin
    if (reset) begin
      lockRun_ff <= 6'h00;
      lockDetect_ff <= 1'b0;
    end else begin
      if (lockClear) lockRun_ff <= 6'h00;
      else if (pfdTick_ff) lockRun_ff <= !errSmall ? 6'h00 : (runHit ? lockRun_ff : runNext);
      // A lock event in the same cycle as a clear is kept
      if (runHit) lockDetect_ff <= 1'b1;
      else if (lockClear || (pfdTick_ff && errLarge)) lockDetect_ff <= 1'b0;
    end
  end

  // Fast lock: a zero timer gives no boost at all
  logic fastLock_ff;
  logic [11:0] fastCount_ff;
  wire fastStart = feedbackWrite && inFeedback.fastLock && (timerValue_ff != 12'h000);
  always_ff @(posedge mclk) begin
    if (reset || controlWord_ff.powerDown) begin
      fastLock_ff <= 1'b0;
      fastCount_ff <= 12'h000;
    end else if (fastStart) begin
      fastLock_ff <= 1'b1;
      fastCount_ff <= timerValue_ff;
    end else if (fastLock_ff && pfdTick_ff) begin
      fastCount_ff <= fastCount_ff - 12'h001;
      if (fastCount_ff == 12'h001) fastLock_ff <= 1'b0;
    end
  end

  // Test output; the fast-lock switch pulls low only while boosting
  wire [2:0] testSel = referenceWord_ff.testOutputSelect;
  wire testLevel = (testSel == sp_pkg::SEL_LOCK) ? lockDetect_ff :
                   (testSel == sp_pkg::SEL_HIGH) ? 1'b1 :
                   (testSel == sp_pkg::SEL_REF_DIV) ? pfdTick_ff : 1'b0;
  wire testDrive = (testSel != sp_pkg::SEL_THREE_STATE) &&
                   ((testSel != sp_pkg::SEL_FAST_LOCK) || fastLock_ff);
  wire highZNext = controlWord_ff.pumpThreeState | controlWord_ff.powerDown;

  logic testOut_ff, testOutEn_ff, pumpHighZ_ff, ditherEn_ff, counterHold_ff;
  logic [4:0] pumpGain_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      {testOut_ff, testOutEn_ff, ditherEn_ff, counterHold_ff} <= 4'h0;
      pumpHighZ_ff <= 1'b0;
      pumpGain_ff <= sp_pkg::PUMP_GAIN_NORMAL;
    end else begin
      testOut_ff <= testLevel;
      testOutEn_ff <= testDrive;
      pumpHighZ_ff <= highZNext;
      ditherEn_ff <= ~noiseWord_ff.ditherOff;
      counterHold_ff <= countersHeld;
      pumpGain_ff <= fastLock_ff ? sp_pkg::PUMP_GAIN_BOOST : sp_pkg::PUMP_GAIN_NORMAL;
    end
  end

  // Outputs
  assign testOut = testOut_ff;
  assign testOutEn = testOutEn_ff;
  assign lockDetect = lockDetect_ff;
  assign pumpGain = pumpGain_ff;
  assign pumpHighZ = pumpHighZ_ff;
  assign phasePolarity = controlWord_ff.phasePolarity;
  assign pumpCurrentSet = controlWord_ff.pumpCurrent;
  assign pumpNoiseBias = noiseWord_ff.pumpNoiseBias;
  assign ditherEn = ditherEn_ff;
  assign counterHold = counterHold_ff;
  assign powerDown = controlWord_ff.powerDown;
  assign prescalerHigh = referenceWord_ff.prescalerHigh;
  assign refDoublerEn = controlWord_ff.refDoubler;
  assign wholeDivide = feedbackWord_ff.wholeDivide;
  assign partialStepNumerator = feedbackWord_ff.partialStepNumerator;
  assign fractionDenominator = denomActive_ff;
  assign phaseComparatorTick = pfdTick_ff;

  // Checks
  property p_route_feedback;
    feedbackWrite |=> feedbackWord_ff == $past(shiftWord_ff);
  endproperty
  a_route_feedback: assert property (p_route_feedback) else $error("feedback word not loaded");

  property p_route_reference;
    referenceWrite |=> referenceWord_ff == $past(shiftWord_ff) && $stable(feedbackWord_ff);
  endproperty
  a_route_reference: assert property (p_route_reference) else $error("reference word not loaded");

  property p_route_control;
    controlWrite |=> controlWord_ff == $past(shiftWord_ff) && $stable(noiseWord_ff);
  endproperty
  a_route_control: assert property (p_route_control) else $error("control word not loaded");

  property p_route_noise;
    noiseWrite |=> noiseWord_ff == $past(shiftWord_ff) && $stable(controlWord_ff);
  endproperty
  a_route_noise: assert property (p_route_noise) else $error("noise word not loaded");

  property p_strobe_only;
    !loadRise |=> $stable(feedbackWord_ff) && $stable(controlWord_ff) && $stable(referenceWord_ff);
  endproperty
  a_strobe_only: assert property (p_strobe_only) else $error("register changed without strobe");

  property p_timer_keeps_denom;
    referenceWrite && inReference.loadTimer |=> $stable(denomPending_ff) &&
      timerValue_ff == $past(inReference.value);
  endproperty
  a_timer_keeps_denom: assert property (p_timer_keeps_denom) else $error("timer load touched denominator");

  property p_denom_buffered;
    !feedbackWrite |=> $stable(fractionDenominator);
  endproperty
  a_denom_buffered: assert property (p_denom_buffered) else $error("denominator changed early");

  property p_boost;
    fastStart && !controlWord_ff.powerDown |=> ##1 pumpGain == sp_pkg::PUMP_GAIN_BOOST;
  endproperty
  a_boost: assert property (p_boost) else $error("fast lock did not boost pump");

  property p_boost_end;
    fastLock_ff && pfdTick_ff && fastCount_ff == 12'h001 && !fastStart |=>
      !fastLock_ff ##1 pumpGain == sp_pkg::PUMP_GAIN_NORMAL;
  endproperty
  a_boost_end: assert property (p_boost_end) else $error("boost outlived timer");

  property p_lock_run;
    $rose(lockDetect_ff) |-> $past(runNext) >= $past(runTarget) && $past(pfdTick_ff);
  endproperty
  a_lock_run: assert property (p_lock_run) else $error("lock flagged before full run");

  property p_unlock;
    pfdTick_ff && errLarge |=> !lockDetect;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock kept after large error");

  property p_hold_counters;
    countersHeld |=> refCount_ff == 4'h0 && !phaseComparatorTick;
  endproperty
  a_hold_counters: assert property (p_hold_counters) else $error("counters ran while held");

  property p_pump_highz;
    controlWord_ff.pumpThreeState || controlWord_ff.powerDown |=> pumpHighZ;
  endproperty
  a_pump_highz: assert property (p_pump_highz) else $error("pump not three-stated");

  property p_dither;
    noiseWrite |=> ##1 ditherEn == !$past(inFeedback.partialStepNumerator[0], 2);
  endproperty
  a_dither: assert property (p_dither) else $error("dither not set by mode");

  // Held counters are left out: their reset branch overrides any counting
  property p_ratio_wrap;
    refWrap && !countersHeld |=> pfdTick_ff && refCount_ff == 4'h0;
  endproperty
  a_ratio_wrap: assert property (p_ratio_wrap) else $error("divider did not wrap at ratio");

  property p_ref_step;
    refEdge && !refWrap && !countersHeld |=> refCount_ff == $past(refCount_ff) + 4'h1;
  endproperty
  a_ref_step: assert property (p_ref_step) else $error("divider missed an active edge");

  property p_rise_ignored;
    !controlWord_ff.refDoubler && refSync2_ff && !refPrev_ff && !countersHeld |=>
      $stable(refCount_ff) && !pfdTick_ff;
  endproperty
  a_rise_ignored: assert property (p_rise_ignored) else $error("rising edge counted without doubler");

  property p_run_break;
    pfdTick_ff && !errSmall && !lockClear |=> lockRun_ff == 6'h00;
  endproperty
  a_run_break: assert property (p_run_break) else $error("lock run kept after an error window");

  property p_fast_count;
    fastLock_ff && pfdTick_ff && !fastStart && !controlWord_ff.powerDown |=>
      fastCount_ff == $past(fastCount_ff) - 12'h001;
  endproperty
  a_fast_count: assert property (p_fast_count) else $error("timer did not count a comparator cycle");

  property p_gain_normal;
    !fastLock_ff |=> pumpGain == sp_pkg::PUMP_GAIN_NORMAL;
  endproperty
  a_gain_normal: assert property (p_gain_normal) else $error("pump boosted outside fast lock");

  property p_power_clears;
    controlWord_ff.powerDown && !pfdTick_ff |=> !lockDetect_ff && !fastLock_ff;
  endproperty
  a_power_clears: assert property (p_power_clears) else $error("lock or fast lock kept while down");

  property p_pump_normal;
    !controlWord_ff.pumpThreeState && !controlWord_ff.powerDown |=> !pumpHighZ;
  endproperty
  a_pump_normal: assert property (p_pump_normal) else $error("pump three-stated without cause");

  property p_hold_output;
    countersHeld |=> counterHold;
  endproperty
  a_hold_output: assert property (p_hold_output) else $error("counter hold not shown");

  c_fast_lock_done: cover property (fastLock_ff ##1 !fastLock_ff);
  c_lock_lost: cover property ($fell(lockDetect));
  c_lock_gained: cover property ($rose(lockDetect));
  c_doubled_tick: cover property (controlWord_ff.refDoubler && pfdTick_ff);
  c_denom_applied: cover property (feedbackWrite ##1 $changed(fractionDenominator));
endmodule

// File: include/sp_pkg.sv
package sp_pkg;
  // Word routing codes in the two lowest bits
  localparam logic [1:0] ADDR_FEEDBACK = 2'h0;
  localparam logic [1:0] ADDR_REFERENCE = 2'h1;
  localparam logic [1:0] ADDR_CONTROL = 2'h2;
  localparam logic [1:0] ADDR_NOISE = 2'h3;
  localparam int WORD_W = 24;

  typedef struct packed {
    logic fastLock;
    logic [8:0] wholeDivide;
    logic [11:0] partialStepNumerator;
    logic [1:0] addr;
  } feedback_word_t;

  typedef struct packed {
    logic loadTimer;
    logic [2:0] testOutputSelect;
    logic reserved19;
    logic prescalerHigh;
    logic [3:0] refRatio;
    logic [11:0] value;
    logic [1:0] addr;
  } reference_word_t;

  typedef struct packed {
    logic [11:0] reserved;
    logic refDoubler;
    logic [3:0] pumpCurrent;
    logic phasePolarity;
    logic lockCountPrecision;
    logic powerDown;
    logic pumpThreeState;
    logic counterReset;
    logic [1:0] addr;
  } control_word_t;

  typedef struct packed {
    logic [12:0] reserved;
    logic pumpNoiseBias;
    logic [6:0] reservedLow;
    logic ditherOff;
    logic [1:0] addr;
  } noise_word_t;

  localparam logic [23:0] WORD_RESET = 24'h000000;
  localparam logic [11:0] VALUE_RESET = 12'h000;

  // Test output selections
  localparam logic [2:0] SEL_THREE_STATE = 3'h0;
  localparam logic [2:0] SEL_LOCK = 3'h1;
  localparam logic [2:0] SEL_HIGH = 3'h3;
  localparam logic [2:0] SEL_REF_DIV = 3'h4;
  localparam logic [2:0] SEL_FAST_LOCK = 3'h6;

  localparam logic [5:0] LOCK_RUN_LOW = 6'h18;
  localparam logic [5:0] LOCK_RUN_HIGH = 6'h28;
  localparam logic [4:0] PUMP_GAIN_BOOST = 5'h10;
  localparam logic [4:0] PUMP_GAIN_NORMAL = 5'h01;
  localparam logic [3:0] REF_RATIO_MIN = 4'h1;

  // Phase error windows, measured in mclk cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCK_ERR_NS = 15;
  localparam int UNLOCK_ERR_NS = 30;
  localparam logic [3:0] LOCK_ERR_CYC = 4'((LOCK_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] UNLOCK_ERR_CYC = 4'((UNLOCK_ERR_NS / CLK_PERIOD_NS) < 1 ? 1 : UNLOCK_ERR_NS / CLK_PERIOD_NS);
  localparam logic [3:0] ERR_SAT = 4'hf;
endpackage

// File: testbench/host_model.sv
`timescale 1ns/1ns
module host_model (
  // Serial port to the device
  output logic serialClk,
  output logic serialData,
  output logic loadStrobe,
  // Timing reference for the strobe
  input wire logic mclk
);
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    loadStrobe = 1'b0;
  end
  // Link clock runs only inside a frame; the odd offset keeps it off the mclk phase
  task automatic send(input logic [23:0] w);
    #3;
    for (int i = 23; i >= 0; i--) begin
      serialData = w[i];
      #40 serialClk = 1'b1;
      #40 serialClk = 1'b0;
    end
    // Released data line shows the inverse so a stale bit cannot pass unseen
    serialData = ~w[0];
    @(negedge mclk) loadStrobe = 1'b1;
    repeat (8) @(negedge mclk);
    loadStrobe = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ns
module tb;
  // Short lock runs keep the run brief
  localparam logic [5:0] RUN_LOW = 6'h03;
  localparam logic [5:0] RUN_HIGH = 6'h06;
  logic mclk, serialClk, serialData, loadStrobe;
  logic reset = 1'b1;
  logic referenceInput = 1'b0;
  logic phaseErrorPulse = 1'b0;
  logic testOut, testOutEn, lockDetect, pumpHighZ, phasePolarity, pumpNoiseBias, ditherEn;
  logic counterHold, powerDown, prescalerHigh, refDoublerEn, phaseComparatorTick;
  logic [4:0] pumpGain;
  logic [3:0] pumpCurrentSet;
  logic [8:0] wholeDivide, wd;
  logic [11:0] partialStepNumerator, fractionDenominator, d, num;
  logic [11:0] od = 12'h000;
  logic [1:0] refCnt = 2'h0;
  logic [9:0] f;
  logic [23:0] nw [3];
  int errW = 0, errCnt = 0, fails = 0, checks = 0, cyc = 0, n, g;

  synth_program_registers #(.LOCK_RUN_LOW(RUN_LOW), .LOCK_RUN_HIGH(RUN_HIGH)) uut (
    .mclk(mclk), .reset(reset), .serialClk(serialClk), .serialData(serialData), .loadStrobe(loadStrobe),
    .referenceInput(referenceInput), .phaseErrorPulse(phaseErrorPulse), .testOut(testOut),
    .testOutEn(testOutEn), .lockDetect(lockDetect), .pumpGain(pumpGain), .pumpHighZ(pumpHighZ),
    .phasePolarity(phasePolarity), .pumpCurrentSet(pumpCurrentSet), .pumpNoiseBias(pumpNoiseBias),
    .ditherEn(ditherEn), .counterHold(counterHold), .powerDown(powerDown), .prescalerHigh(prescalerHigh),
    .refDoublerEn(refDoublerEn), .wholeDivide(wholeDivide), .partialStepNumerator(partialStepNumerator),
    .fractionDenominator(fractionDenominator), .phaseComparatorTick(phaseComparatorTick));
  host_model host (.serialClk(serialClk), .serialData(serialData), .loadStrobe(loadStrobe), .mclk(mclk));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Reference period of 8 mclk; error pulse follows each tick for errW cycles
  always @(negedge mclk) begin
    refCnt <= refCnt + 2'h1;
    if (refCnt == 2'h3) begin
      referenceInput <= ~referenceInput;
    end
    if (phaseComparatorTick === 1'b1) begin
      errCnt <= errW;
    end else if (errCnt != 0) begin
      errCnt <= errCnt - 1;
    end
    phaseErrorPulse <= (errCnt != 0);
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      complete_run();
    end
  end

  function automatic logic [23:0] fw(input logic fl, input logic [8:0] w, input logic [11:0] m);
    return {fl, w, m, 2'h0};
  endfunction
  function automatic logic [23:0] rw(input logic lt, input logic [2:0] s, input logic ph, input logic [3:0] r,
                                     input logic [11:0] v);
    return {lt, s, 1'b0, ph, r, v, 2'h1};
  endfunction
  function automatic logic [23:0] cw(input logic [9:0] c);
    return {12'h000, c, 2'h2};
  endfunction
  function automatic int gap_exp(input int r, input logic dbl);
    return dbl ? 4 * r : 8 * r;
  endfunction
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_ticks(input int k);
    repeat (k) @(posedge mclk iff phaseComparatorTick === 1'b1);
  endtask
  task automatic count_ticks(input int k, input logic stopOnNormal);
    n = 0;
    repeat (k) begin
      @(posedge mclk);
      if (phaseComparatorTick === 1'b1) n++;
      if (stopOnNormal && pumpGain === sp_pkg::PUMP_GAIN_NORMAL) break;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h7421348d));
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    chk(pumpGain === sp_pkg::PUMP_GAIN_NORMAL && wholeDivide === 9'h000 && lockDetect === 1'b0
        && fractionDenominator === 12'h000 && testOutEn === 1'b0 && pumpHighZ === 1'b0, "reset state");
    repeat (3) begin
      d = 12'($urandom_range(16, 4095));
      num = 12'($urandom_range(0, d - 1));
      wd = 9'($urandom_range(91, 255));
      host.send(rw(1'b0, 3'h0, d[0], 4'h3, d));
      chk(fractionDenominator === od && prescalerHigh === d[0] && testOutEn === 1'b0, "denominator held");
      host.send(fw(1'b0, wd, num));
      chk(wholeDivide === wd && partialStepNumerator === num, "feedback fields");
      chk(fractionDenominator === d, "denominator applied");
      od = d;
    end
    repeat (4) begin
      f = 10'($urandom);
      host.send(cw(f));
      chk(counterHold === (f[0] | f[2]) && pumpHighZ === (f[1] | f[2]) && powerDown === f[2], "hold");
      chk(phasePolarity === f[4] && pumpCurrentSet === f[8:5] && refDoublerEn === f[9], "fields");
      chk(wholeDivide === wd, "registers kept");
    end
    nw = '{24'h000003, 24'h0003c7, 24'h0007c7};
    for (int i = 0; i < 3; i++) begin
      host.send(nw[i]);
      chk(ditherEn === (i == 0) && pumpNoiseBias === (i == 2), "noise mode");
    end
    for (int i = 0; i < 4; i++) begin
      host.send(rw(1'b0, sp_pkg::SEL_REF_DIV, 1'b0, i[0] ? 4'hf : 4'h1, d));
      host.send(cw({i[1], 9'h000}));
      wait_ticks(1);
      g = 0;
      do begin
        @(posedge mclk);
        g++;
      end while (phaseComparatorTick !== 1'b1);
      chk(g == gap_exp(i[0] ? 15 : 1, i[1]), "comparator spacing");
    end
    host.send(cw(10'h001));
    host.send(rw(1'b1, 3'h0, 1'b0, 4'h3, 12'h005));
    host.send(fw(1'b0, wd, num));
    chk(fractionDenominator === d, "timer leaves denominator");
    host.send(rw(1'b0, sp_pkg::SEL_FAST_LOCK, 1'b0, 4'h3, d));
    host.send(fw(1'b1, wd, num));
    chk(pumpGain === sp_pkg::PUMP_GAIN_BOOST && testOutEn === 1'b1 && testOut === 1'b0, "fast lock on");
    host.send(cw(10'h000));
    count_ticks(2000, 1'b1);
    chk(n == 5 && testOutEn === 1'b0, "fast lock timer");
    // Counters held across the new channel so no tick slips in before counting starts
    host.send(cw(10'h001));
    host.send(fw(1'b0, wd, num));
    host.send(cw(10'h000));
    wait_ticks(2);
    @(negedge mclk);
    chk(lockDetect === 1'b0, "lock too early");
    wait_ticks(2);
    repeat (2) @(negedge mclk);
    chk(lockDetect === 1'b1, "lock after short run");
    host.send(cw(10'h008));
    host.send(fw(1'b0, wd, num));
    chk(lockDetect === 1'b0, "new channel clears lock");
    wait_ticks(4);
    @(negedge mclk);
    chk(lockDetect === 1'b0, "lock before long run");
    wait_ticks(3);
    repeat (2) @(negedge mclk);
    chk(lockDetect === 1'b1, "lock after long run");
    host.send(rw(1'b0, sp_pkg::SEL_LOCK, 1'b0, 4'h3, d));
    chk(testOut === 1'b1 && testOutEn === 1'b1, "lock on test pin");
    errW = 6;
    wait_ticks(2);
    repeat (2) @(negedge mclk);
    chk(lockDetect === 1'b0 && testOut === 1'b0, "large error drops lock");
    errW = 0;
    wait_ticks(8);
    host.send(cw(10'h004));
    chk(powerDown === 1'b1 && pumpHighZ === 1'b1 && counterHold === 1'b1 && lockDetect === 1'b0, "down");
    host.send(fw(1'b0, wd + 9'h100, num));
    chk(wholeDivide === wd + 9'h100, "loading while down");
    count_ticks(300, 1'b0);
    chk(n == 0, "no ticks while down");
    host.send(cw(10'h000));
    chk(powerDown === 1'b0 && wholeDivide === wd + 9'h100, "power restored");
    complete_run();
  end
endmodule
